//--- rtl/pixout_pkg.sv
`default_nettype none
package pixout_pkg;
  localparam int unsigned PIX_W = 12;
  localparam logic [12:0] FULL_COLS = 13'h1120;
  localparam logic [12:0] FULL_ROWS = 13'h0cd8;
  localparam logic [12:0] DARK_COLS = 13'h0008;
  localparam logic [11:0] PEDESTAL_12 = 12'h0a8;
  localparam logic [11:0] PEDESTAL_10 = 12'h02a;
  localparam logic [11:0] CODE_MAX_12 = 12'hfff;
  localparam logic [11:0] CODE_MAX_10 = 12'h3ff;
  localparam logic [11:0] BLACK_RESET = 12'h000;
  localparam int unsigned BLACK_SHIFT = 3;
  localparam int unsigned GAIN_FRAC = 4;
  localparam logic [2:0] PIN_FN_OFF = 3'h0;
  localparam logic [2:0] PIN_FN_TRIGGER = 3'h1;
  localparam logic [2:0] PIN_FN_OE = 3'h2;
  localparam logic [2:0] PIN_FN_ADDR = 3'h3;
  localparam logic [2:0] PIN_FN_STANDBY = 3'h4;
  localparam int unsigned PIN_COUNT = 4;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_BITS = 3;
  localparam logic [1:0] PAR_LAST_PHASE = 2'h1;
  localparam logic [1:0] SER_LAST_PHASE = 2'h2;
  localparam int unsigned FIFO_AW = 4;
  localparam int unsigned MASTER_MIN_MHZ = 2;
  localparam int unsigned MASTER_MAX_MHZ = 64;
  localparam int unsigned SER_PIX_MHZ = 220;
  localparam int unsigned PAR_PIX_MHZ = 96;
  typedef enum logic [0:0] {CORE_IDLE, CORE_LINE} core_state_e;
  typedef struct packed {
    logic sof;
    logic eol;
    logic eof;
    logic [11:0] data;
  } pix_word_s;
endpackage
`default_nettype wire

//--- rtl/pixfifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pixfifo_if;
  logic wr_valid;
  logic wr_ready;
  pixout_pkg::pix_word_s wr_data;
  logic rd_valid;
  logic rd_ready;
  pixout_pkg::pix_word_s rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface
`default_nettype wire

//--- rtl/pixel_cross_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module pixel_cross_fifo (
  input wire logic wr_clk_i,
  input wire logic wr_rst_n_i,
  input wire logic rd_clk_i,
  input wire logic rd_rst_n_i,
  pixfifo_if.fifo port_io
);
  localparam int unsigned AW = pixout_pkg::FIFO_AW;
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] s1;
    logic [AW:0] s2;
  } side_s;
  side_s w_q, w_d, r_q, r_d;
  pixout_pkg::pix_word_s mem_q [2**AW];
  logic full;
  logic empty;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // pointers cross as gray code; s1 feeds only s2
  always_comb begin
    w_d = w_q;
    w_d.s1 = r_q.gray;
    w_d.s2 = w_q.s1;
    full = (w_q.gray == {~w_q.s2[AW:AW-1], w_q.s2[AW-2:0]});
    if (port_io.wr_valid && !full) begin
      w_d.bin = w_q.bin + 1'b1;
      w_d.gray = to_gray(w_d.bin);
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.s1 = w_q.gray;
    r_d.s2 = r_q.s1;
    empty = (r_q.gray == r_q.s2);
    if (port_io.rd_ready && !empty) begin
      r_d.bin = r_q.bin + 1'b1;
      r_d.gray = to_gray(r_d.bin);
    end
  end

  always_ff @(posedge wr_clk_i or negedge wr_rst_n_i) begin
    if (!wr_rst_n_i) begin
      w_q <= '0;
    end else begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge rd_clk_i or negedge rd_rst_n_i) begin
    if (!rd_rst_n_i) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  always_ff @(posedge wr_clk_i) begin
    if (port_io.wr_valid && !full) begin
      mem_q[w_q.bin[AW-1:0]] <= port_io.wr_data;
    end
  end

  assign port_io.wr_ready = !full;
  assign port_io.rd_valid = !empty;
  assign port_io.rd_data = mem_q[r_q.bin[AW-1:0]];
endmodule
`default_nettype wire

//--- rtl/rolling_readout_pixel_output.sv
`timescale 1ns/1ps
`default_nettype none
module rolling_readout_pixel_output (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic [11:0] adc_sample_i,
  input wire logic [12:0] frame_cols_i,
  input wire logic [12:0] frame_rows_i,
  input wire logic [12:0] exposure_rows_i,
  input wire logic [31:0] color_gain_i,
  input wire logic adc_10bit_i,
  input wire logic parallel_mode_i,
  input wire logic high_common_mode_i,
  input wire logic [11:0] pin_function_i,
  input wire logic [3:0] general_input_pin_i,
  input wire logic shutter_closed_i,
  output logic row_reset_o,
  output logic [12:0] row_reset_addr_o,
  output logic row_read_o,
  output logic [12:0] row_read_addr_o,
  output logic flash_o,
  output logic shutter_open_o,
  output logic standby_o,
  output logic bus_address_select_o,
  output logic high_common_mode_signalling_o,
  output logic fifo_overflow_o,
  output logic frame_busy_o,
  output logic pixel_output_clock_o,
  output logic row_qualifier_short_o,
  output logic frame_qualifier_short_o,
  output logic [11:0] pixel_data_o,
  output logic pixel_data_oe_o,
  output logic [3:0] serial_lane_o
);
  typedef struct packed {
    pixout_pkg::core_state_e st;
    logic [3:0] pin1;
    logic [3:0] pin2;
    logic [3:0] pin3;
    logic shut1;
    logic shut2;
    logic [11:0] gfun;
    logic [12:0] cols;
    logic [12:0] rows;
    logic [12:0] exp;
    logic par;
    logic b10;
    logic [13:0] line;
    logic [12:0] col;
    logic [11:0] black;
    logic first_px;
    logic rst_stb;
    logic [12:0] rst_addr;
    logic rd_stb;
    logic [12:0] rd_addr;
    logic flash;
    logic shutter;
    logic standby;
    logic addr_sel;
    logic oe;
    logic hcm_sel;
    logic ovf;
    logic wr_valid;
    pixout_pkg::pix_word_s wr_data;
  } core_s;

  typedef struct packed {
    logic par1;
    logic par2;
    logic oe1;
    logic oe2;
    logic [1:0] ph;
    logic [11:0] shift;
    logic pclk;
    logic rowq;
    logic frmq;
    logic frmq_end;
    logic [11:0] data;
    logic oe_out;
    logic [3:0] lanes;
  } link_s;

  core_s c_q, c_d;
  link_s l_q, l_d;
  logic [1:0] lrst_q;
  logic link_rst_n;
  pixfifo_if fifo_port ();

  function automatic logic [3:0] pin_mask(input logic [11:0] fun, input logic [2:0] code);
    logic [3:0] m;
    m = '0;
    for (int i = 0; i < pixout_pkg::PIN_COUNT; i++) begin
      m[i] = (fun[i*3 +: 3] == code);
    end
    return m;
  endfunction

  function automatic logic [11:0] saturate(input logic [16:0] x, input logic [11:0] lim);
    return (x > {5'h00, lim}) ? lim : x[11:0];
  endfunction

  // colour slot: 0 green-on-red-row, 1 red, 2 blue, 3 green-on-blue-row
  function automatic logic [1:0] bayer_slot(input logic row_odd, input logic col_odd);
    return {row_odd, col_odd};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // row timing and pixel chain, master clock domain

  logic [3:0] trig_m;
  logic [3:0] oe_m;
  logic trig_edge;
  logic reading;
  logic [13:0] read_row;
  logic [13:0] last_line;
  logic [12:0] pcol;
  logic [11:0] samp;
  logic [11:0] above;
  logic [7:0] gain;
  logic [19:0] prod;
  logic [11:0] ped;
  logic [11:0] lim;
  logic signed [12:0] diff;

  always_comb begin
    c_d = c_q;
    c_d.pin1 = general_input_pin_i;
    c_d.pin2 = c_q.pin1;
    c_d.pin3 = c_q.pin2;
    c_d.shut1 = shutter_closed_i;
    c_d.shut2 = c_q.shut1;
    c_d.gfun = pin_function_i;
    trig_m = pin_mask(c_q.gfun, pixout_pkg::PIN_FN_TRIGGER);
    oe_m = pin_mask(c_q.gfun, pixout_pkg::PIN_FN_OE);
    trig_edge = |(trig_m & c_q.pin2 & ~c_q.pin3);
    c_d.standby = |(pin_mask(c_q.gfun, pixout_pkg::PIN_FN_STANDBY) & c_q.pin2);
    c_d.addr_sel = |(pin_mask(c_q.gfun, pixout_pkg::PIN_FN_ADDR) & c_q.pin2);
    // enable pins are active low; with none assigned the outputs stay enabled in parallel mode
    c_d.oe = ~|(oe_m & c_q.pin2);
    c_d.hcm_sel = high_common_mode_i;
    c_d.rst_stb = 1'b0;
    c_d.rd_stb = 1'b0;
    c_d.wr_valid = 1'b0;
    c_d.ovf = c_q.ovf | (c_q.wr_valid & ~fifo_port.wr_ready);
    reading = (c_q.line >= {1'b0, c_q.exp});
    read_row = c_q.line - {1'b0, c_q.exp};
    last_line = {1'b0, c_q.rows} + {1'b0, c_q.exp} - 14'h0001;
    pcol = c_q.col - pixout_pkg::DARK_COLS;
    samp = c_q.b10 ? {2'b00, adc_sample_i[11:2]} : adc_sample_i;
    above = (samp > c_q.black) ? (samp - c_q.black) : 12'h000;
    gain = color_gain_i[bayer_slot(read_row[0], pcol[0])*8 +: 8];
    prod = above * gain;
    ped = c_q.b10 ? pixout_pkg::PEDESTAL_10 : pixout_pkg::PEDESTAL_12;
    lim = c_q.b10 ? pixout_pkg::CODE_MAX_10 : pixout_pkg::CODE_MAX_12;
    diff = $signed({1'b0, samp}) - $signed({1'b0, c_q.black});
    case (c_q.st)
      pixout_pkg::CORE_IDLE: begin
        c_d.flash = 1'b0;
        c_d.shutter = 1'b0;
        // standby only takes effect between frames so no frame is cut short
        if (!c_q.standby && (~|trig_m || trig_edge)) begin
          // size, exposure and mode are frozen for the whole frame
          c_d.cols = (frame_cols_i == 13'h0000) ? pixout_pkg::FULL_COLS : frame_cols_i;
          c_d.rows = (frame_rows_i == 13'h0000) ? pixout_pkg::FULL_ROWS : frame_rows_i;
          c_d.exp = exposure_rows_i;
          c_d.par = parallel_mode_i;
          c_d.b10 = adc_10bit_i;
          c_d.line = '0;
          c_d.col = '0;
          c_d.first_px = 1'b1;
          c_d.flash = ~c_q.shut2;
          c_d.shutter = 1'b1;
          c_d.st = pixout_pkg::CORE_LINE;
        end
      end
      pixout_pkg::CORE_LINE: begin
        if (c_q.col == 13'h0000) begin
          if (c_q.line < {1'b0, c_q.rows}) begin
            c_d.rst_stb = 1'b1;
            c_d.rst_addr = c_q.line[12:0];
          end
          if (reading) begin
            c_d.rd_stb = 1'b1;
            c_d.rd_addr = read_row[12:0];
          end
        end
        if (reading) begin
          if (c_q.col < pixout_pkg::DARK_COLS) begin
            c_d.black = 12'($signed({1'b0, c_q.black}) + (diff >>> pixout_pkg::BLACK_SHIFT));
          end else begin
            c_d.wr_valid = 1'b1;
            c_d.wr_data.data = saturate(17'(prod[19:pixout_pkg::GAIN_FRAC]) + 17'(ped), lim);
            c_d.wr_data.sof = c_q.first_px;
            c_d.wr_data.eol = (pcol == c_q.cols - 13'h0001);
            c_d.wr_data.eof = c_d.wr_data.eol && (read_row[12:0] == c_q.rows - 13'h0001);
            c_d.first_px = 1'b0;
          end
        end
        // flash lights until the first row is read out
        c_d.flash = ~c_q.shut2 && (c_q.line < {1'b0, c_q.exp});
        c_d.shutter = (c_q.line < last_line);
        if (c_q.col == pixout_pkg::DARK_COLS + c_q.cols - 13'h0001) begin
          c_d.col = '0;
          if (c_q.line == last_line) begin
            c_d.st = pixout_pkg::CORE_IDLE;
            c_d.flash = 1'b0;
            c_d.shutter = 1'b0;
          end else begin
            c_d.line = c_q.line + 14'h0001;
          end
        end else begin
          c_d.col = c_q.col + 13'h0001;
        end
      end
      default: begin
        c_d.st = pixout_pkg::CORE_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c_q <= '0;
      c_q.black <= pixout_pkg::BLACK_RESET;
      c_q.oe <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  assign fifo_port.wr_valid = c_q.wr_valid;
  assign fifo_port.wr_data = c_q.wr_data;

  read_after_gap_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    c_q.rd_stb |-> ({1'b0, c_q.rd_addr} + {1'b0, c_q.exp} == c_q.line))
    else $error("row read not one exposure gap after its reset");
  reset_strobe_gap_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    c_q.rst_stb |=> !c_q.rst_stb [*7])
    else $error("row reset strobes closer than one line");
  ten_bit_range_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    c_q.wr_valid && c_q.b10 |-> c_q.wr_data.data <= pixout_pkg::CODE_MAX_10)
    else $error("10-bit sample above range");
  pedestal_floor_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    c_q.wr_valid |-> c_q.wr_data.data >= (c_q.b10 ? pixout_pkg::PEDESTAL_10 : pixout_pkg::PEDESTAL_12))
    else $error("pixel below pedestal");
  inputs_off_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (c_q.gfun == 12'h000) |=> !c_q.standby && !c_q.addr_sel)
    else $error("unassigned general input had an effect");
  flash_in_frame_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    c_q.flash |-> c_q.st == pixout_pkg::CORE_LINE && c_q.shutter)
    else $error("flash outside exposure");

  ////////////////////////////////////////////////////////////////////////////
  // continuity buffer between the domains

  // frames arrive in bursts of one row; the buffer spreads them at link pace
  pixel_cross_fifo u_fifo (
    .wr_clk_i(ref_clk_i),
    .wr_rst_n_i(reset_n_i),
    .rd_clk_i(link_clk_i),
    .rd_rst_n_i(link_rst_n),
    .port_io(fifo_port)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output link, PLL-derived link clock domain

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_q[1];

  logic [1:0] last_ph;
  logic pop;
  logic [11:0] src;

  always_comb begin
    l_d = l_q;
    l_d.par1 = c_q.par;
    l_d.par2 = l_q.par1;
    l_d.oe1 = c_q.oe;
    l_d.oe2 = l_q.oe1;
    l_d.oe_out = l_q.par2 && l_q.oe2;
    last_ph = l_q.par2 ? pixout_pkg::PAR_LAST_PHASE : pixout_pkg::SER_LAST_PHASE;
    pop = (l_q.ph == 2'h0) && fifo_port.rd_valid;
    src = l_q.shift;
    if (l_q.ph == 2'h0) begin
      l_d.pclk = 1'b0;
      l_d.ph = 2'h1;
      if (l_q.frmq_end) begin
        l_d.frmq = 1'b0;
        l_d.frmq_end = 1'b0;
      end
      if (pop) begin
        l_d.rowq = 1'b1;
        if (fifo_port.rd_data.sof) begin
          l_d.frmq = 1'b1;
        end
        l_d.frmq_end = fifo_port.rd_data.eof;
        l_d.data = l_q.par2 ? fifo_port.rd_data.data : 12'h000;
        l_d.shift = fifo_port.rd_data.data;
        src = fifo_port.rd_data.data;
      end else begin
        l_d.rowq = 1'b0;
        l_d.shift = 12'h000;
        src = 12'h000;
      end
    end else begin
      // parallel: data settles while the clock is low, host samples on its rise
      l_d.pclk = l_q.par2;
      l_d.ph = (l_q.ph == last_ph) ? 2'h0 : 2'(l_q.ph + 2'h1);
    end
    // serial: each lane carries three bits of the word, most significant first
    for (int k = 0; k < pixout_pkg::LANES; k++) begin
      l_d.lanes[k] = !l_q.par2 && src[k*pixout_pkg::LANE_BITS + 2 - int'(l_q.ph)];
    end
  end

  always_ff @(posedge link_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign fifo_port.rd_ready = (l_q.ph == 2'h0);

  line_in_frame_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    l_q.rowq |-> l_q.frmq)
    else $error("line qualifier outside frame");
  serial_no_clock_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    !l_q.par2 |=> !l_q.pclk)
    else $error("pixel clock running in serial mode");
  pclk_half_rate_a: assert property (@(posedge link_clk_i) disable iff (!link_rst_n)
    $rose(l_q.pclk) |=> !l_q.pclk ##1 l_q.pclk || !l_q.par2)
    else $error("pixel clock not half the link clock");

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign row_reset_o = c_q.rst_stb;
  assign row_reset_addr_o = c_q.rst_addr;
  assign row_read_o = c_q.rd_stb;
  assign row_read_addr_o = c_q.rd_addr;
  assign flash_o = c_q.flash;
  assign shutter_open_o = c_q.shutter;
  assign standby_o = c_q.standby;
  assign bus_address_select_o = c_q.addr_sel;
  assign high_common_mode_signalling_o = c_q.hcm_sel;
  assign fifo_overflow_o = c_q.ovf;
  assign frame_busy_o = (c_q.st == pixout_pkg::CORE_LINE);
  assign pixel_output_clock_o = l_q.pclk;
  assign row_qualifier_short_o = l_q.rowq;
  assign frame_qualifier_short_o = l_q.frmq;
  assign pixel_data_o = l_q.data;
  assign pixel_data_oe_o = l_q.oe_out;
  assign serial_lane_o = l_q.lanes;
endmodule
`default_nettype wire

//--- testbench/isp_receiver.sv
`timescale 1ns/1ps
`default_nettype none
module isp_receiver (
  input wire logic link_clk_i,
  input wire logic reset_n_i,
  input wire logic parallel_i,
  input wire logic pclk_i,
  input wire logic rowq_i,
  input wire logic frmq_i,
  input wire logic [11:0] data_i,
  input wire logic [3:0] lane_i
);
  logic [11:0] rx_q[$];
  int n_bad;
  int phase;
  logic pclk_last;
  logic [11:0] word;
  // sampled on the falling edge so the design's link flops have settled
  always @(negedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_q.delete();
      n_bad = 0;
      phase = 0;
      pclk_last = 1'b0;
      word = 12'h000;
    end else begin
      if (rowq_i === 1'b1 && frmq_i !== 1'b1) n_bad++;
      if (parallel_i) begin
        if (pclk_i === 1'b1 && pclk_last === 1'b0 && rowq_i === 1'b1) rx_q.push_back(data_i);
      end else begin
        if (pclk_i !== 1'b0) n_bad++;
        if (rowq_i === 1'b1) begin
          for (int k = 0; k < 4; k++) word[3*k+2-phase] = lane_i[k];
          if (phase == 2) begin
            rx_q.push_back(word);
            phase = 0;
          end else begin
            phase++;
          end
        end else begin
          // a gap always ends a pixel period, so realign on the next one
          phase = 0;
        end
      end
      pclk_last = pclk_i;
    end
  end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic ref_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] adc_sample_i = 12'h000;
  logic [12:0] frame_cols_i = 13'h0004;
  logic [12:0] frame_rows_i = 13'h0002;
  logic [12:0] exposure_rows_i = 13'h0000;
  logic [31:0] color_gain_i = 32'h10101010;
  logic adc_10bit_i = 1'b0;
  logic parallel_mode_i = 1'b0;
  logic high_common_mode_i = 1'b0;
  // pin3 trigger, pin2 output enable, pin1 address select, pin0 standby
  logic [11:0] pin_function_i = 12'h29c;
  logic [3:0] general_input_pin_i = 4'h0;
  logic shutter_closed_i = 1'b0;
  logic row_reset_o, row_read_o, flash_o, shutter_open_o, standby_o, bus_address_select_o;
  logic high_common_mode_signalling_o, fifo_overflow_o, frame_busy_o, pixel_output_clock_o;
  logic row_qualifier_short_o, frame_qualifier_short_o, pixel_data_oe_o;
  logic [12:0] row_reset_addr_o, row_read_addr_o;
  logic [11:0] pixel_data_o;
  logic [3:0] serial_lane_o;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'h87e6;
  int cyc = 0;
  int n;
  logic [12:0] rst_q[$], rd_q[$];
  int rst_t[$], rd_t[$];
  always #20 ref_clk_i = ~ref_clk_i;
  initial begin
    #2.7;
    forever #6 link_clk_i = ~link_clk_i;
  end
  rolling_readout_pixel_output dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .link_clk_i(link_clk_i), .adc_sample_i(adc_sample_i), .frame_cols_i(frame_cols_i),
    .frame_rows_i(frame_rows_i), .exposure_rows_i(exposure_rows_i),
    .color_gain_i(color_gain_i), .adc_10bit_i(adc_10bit_i), .parallel_mode_i(parallel_mode_i),
    .high_common_mode_i(high_common_mode_i), .pin_function_i(pin_function_i),
    .general_input_pin_i(general_input_pin_i), .shutter_closed_i(shutter_closed_i),
    .row_reset_o(row_reset_o), .row_reset_addr_o(row_reset_addr_o), .row_read_o(row_read_o),
    .row_read_addr_o(row_read_addr_o), .flash_o(flash_o), .shutter_open_o(shutter_open_o),
    .standby_o(standby_o), .bus_address_select_o(bus_address_select_o),
    .high_common_mode_signalling_o(high_common_mode_signalling_o),
    .fifo_overflow_o(fifo_overflow_o), .frame_busy_o(frame_busy_o),
    .pixel_output_clock_o(pixel_output_clock_o), .row_qualifier_short_o(row_qualifier_short_o),
    .frame_qualifier_short_o(frame_qualifier_short_o), .pixel_data_o(pixel_data_o),
    .pixel_data_oe_o(pixel_data_oe_o), .serial_lane_o(serial_lane_o));
  isp_receiver rcv (.link_clk_i(link_clk_i), .reset_n_i(reset_n_i),
    .parallel_i(parallel_mode_i), .pclk_i(pixel_output_clock_o),
    .rowq_i(row_qualifier_short_o), .frmq_i(frame_qualifier_short_o), .data_i(pixel_data_o),
    .lane_i(serial_lane_o));
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge ref_clk_i) begin
    cyc++;
    if (row_reset_o === 1'b1) begin
      rst_q.push_back(row_reset_addr_o);
      rst_t.push_back(cyc);
    end
    if (row_read_o === 1'b1) begin
      rd_q.push_back(row_read_addr_o);
      rd_t.push_back(cyc);
    end
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(negedge ref_clk_i);
    rst_q.delete();
    rd_q.delete();
    rst_t.delete();
    rd_t.delete();
    `CHK("outputs in reset", 0, {frame_busy_o, row_qualifier_short_o, frame_qualifier_short_o,
      pixel_data_o, pixel_data_oe_o, serial_lane_o, flash_o, pixel_output_clock_o})
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic pulse_trigger(input logic [3:0] base);
    @(posedge ref_clk_i);
    general_input_pin_i <= base | 4'h8;
    repeat (4) @(posedge ref_clk_i);
    general_input_pin_i <= base;
  endtask
  // a fresh reset per frame starts the black tracker from its reset value
  task automatic run_frame(input int par, input int b10, input int cols, input int rows,
    input int ex);
    logic [31:0] gn;
    int s, blk, d, v, mx, ped, k, r, c;
    gn = $random(seed);
    s = $random(seed) & 32'h00000fff;
    @(posedge ref_clk_i);
    parallel_mode_i <= par[0];
    adc_10bit_i <= b10[0];
    frame_cols_i <= cols[12:0];
    frame_rows_i <= rows[12:0];
    exposure_rows_i <= ex[12:0];
    color_gain_i <= gn;
    adc_sample_i <= s[11:0];
    // zero on the width port selects the full still width
    if (cols == 0) cols = 4384;
    do_reset();
    n = 0;
    while (frame_busy_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("flash and shutter at start", 2'h3, {flash_o, shutter_open_o})
    n = 0;
    while (frame_busy_o !== 1'b0 && n < 20000) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("busy and flash after frame", 2'h0, {frame_busy_o, flash_o})
    repeat (60) @(negedge ref_clk_i);
    `CHK("reset count", rows, rst_q.size())
    `CHK("read count", rows, rd_q.size())
    for (k = 0; k < rows && k < rst_q.size() && k < rd_q.size(); k++) begin
      `CHK("reset row", k, rst_q[k])
      `CHK("read row", k, rd_q[k])
      `CHK("exposure gap", ex * (8 + cols), rd_t[k] - rst_t[k])
    end
    `CHK("output enable", par, pixel_data_oe_o)
    `CHK("qualifier faults", 0, rcv.n_bad)
    `CHK("pixel count", rows * cols, rcv.rx_q.size())
    `CHK("no overflow", 0, fifo_overflow_o)
    mx = b10 ? 1023 : 4095;
    ped = b10 ? 42 : 168;
    s = b10 ? s >> 2 : s;
    blk = 0;
    k = 0;
    for (r = 0; r < rows; r++) begin
      repeat (8) blk = blk + ((s - blk) >>> 3);
      for (c = 0; c < cols; c++) begin
        d = (s > blk) ? s - blk : 0;
        v = ((d * gn[8 * ((r % 2) * 2 + c % 2) +: 8]) >> 4) + ped;
        if (v > mx) v = mx;
        if (k < rcv.rx_q.size()) `CHK("pixel", v, rcv.rx_q[k])
        k++;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    run_frame(0, 0, 4, 2, 1);
    run_frame(1, 0, 5, 3, 0);
    run_frame(0, 1, 3, 4, 2);
    run_frame(1, 1, 4, 2, 1);
    run_frame(0, 0, 0, 2, 0);
    for (int i = 1; i >= 0; i--) begin
      @(posedge ref_clk_i);
      high_common_mode_i <= i[0];
      repeat (4) @(negedge ref_clk_i);
      `CHK("common mode select", i, high_common_mode_signalling_o)
    end
    @(posedge ref_clk_i);
    general_input_pin_i <= 4'h6;
    repeat (6) @(negedge ref_clk_i);
    `CHK("oe off and address", 2'h1, {pixel_data_oe_o, bus_address_select_o})
    @(posedge ref_clk_i);
    general_input_pin_i <= 4'h1;
    repeat (6) @(negedge ref_clk_i);
    `CHK("standby pin", 2'h2, {standby_o, bus_address_select_o})
    pulse_trigger(4'h1);
    repeat (20) @(negedge ref_clk_i);
    `CHK("no frame in standby", 0, frame_busy_o)
    @(posedge ref_clk_i);
    general_input_pin_i <= 4'h0;
    shutter_closed_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    pulse_trigger(4'h0);
    n = 0;
    while (frame_busy_o !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("triggered frame", 1, frame_busy_o)
    `CHK("flash held off by shutter", 2'h1, {flash_o, shutter_open_o})
    finish_test();
  end
  // the full-width frame dominates: about 10000 reference cycles in all
  initial begin
    #1600000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
